// ---- verification/vfe_ctrl_bench.sv ----
// self-checking bench for the sample and clamp control block
`timescale 1ns/100ps
`include "vfe_map.svh"
module vfe_ctrl_bench;
  import vfe_pkg::*;
  logic clk_sys = 0, sys_rst = 1, power_on_reset_n = 0, wr_en = 0;
  logic wr_soft_reset = 0, wr_clamp_enable_bit = 0, wr_ofs_gain = 0;
  logic wr_clamp_source_select = 0, wr_double_sample_enable = 0;
  logic wr_output_disable_bit = 0, output_disable_pin = 0;
  vfe_mode_e wr_mode = VFE_THREE;
  vfe_chan_e wr_mono_sel = VFE_RED;
  logic [1:0] wr_chan = 0, mux_sel, mode, mono_sel, pixel_chan;
  logic [7:0] wr_offset = 0;
  logic [8:0] wr_gain = 0;
  logic reset_sample_pulse, video_sample_pulse, shared_clamp_control;
  logic video_capture, reset_capture, ref_pin_capture, clamp_enable_bit;
  logic double_sample_enable, output_disable_bit, pixel_output_oe;
  logic pixel_valid, go = 0, rs_lvl = 0, vs_lvl = 0, busy;
  logic [9:0] adc_word, pixel_output_bus, word = 0;
  logic [2:0] chan_power_up;
  logic [23:0] offset_bus, ofs_x;
  logic [26:0] gain_bus, gn_x;
  logic [11:0] e;
  logic [11:0] exp_q[$];
  int bad_count = 0, n_tests = 0, cv, cr, cp, el, m, s;
  int unsigned dummy;
  realtime t_fall = 0;
  vfe_ctrl vfe_ctrl_i (.clk_sys, .sys_rst, .power_on_reset_n, .wr_en,
    .wr_soft_reset, .wr_clamp_enable_bit, .wr_clamp_source_select,
    .wr_double_sample_enable, .wr_output_disable_bit, .wr_mode,
    .wr_mono_sel, .wr_chan, .wr_ofs_gain, .wr_offset, .wr_gain,
    .reset_sample_pulse, .video_sample_pulse, .output_disable_pin,
    .adc_word, .shared_clamp_control, .video_capture, .reset_capture,
    .ref_pin_capture, .chan_power_up, .mux_sel, .offset_bus, .gain_bus,
    .clamp_enable_bit, .double_sample_enable, .output_disable_bit, .mode,
    .mono_sel, .pixel_output_bus, .pixel_output_oe, .pixel_valid,
    .pixel_chan);
  vfe_scan_timing vfe_scan_timing_i (.clk_sys, .go, .word, .rs_lvl,
    .vs_lvl, .reset_sample_pulse, .video_sample_pulse, .adc_word, .busy);
  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  // remember the last video fall for the latency figure
  always @(negedge video_sample_pulse) t_fall = $realtime;
  task automatic check(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // scoreboard: every word seen takes the oldest note off the queue
  always @(posedge clk_sys) begin
    cv += (video_capture === 1'b1);
    cr += (reset_capture === 1'b1);
    cp += (ref_pin_capture === 1'b1);
    if (pixel_valid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hFFF;
      el = int'(($realtime - t_fall) / 10.0);
      check("chan", pixel_chan, e[11:10]);
      check("mux", mux_sel, e[11:10]);
      check("data", pixel_output_bus, e[9:0]);
      check("oe", pixel_output_oe, 1);
      check("lat", el >= 14 && el <= 40, 1);
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr_cfg(input logic ce, cs, ds, od, input int m, s);
    @(posedge clk_sys);
    wr_clamp_enable_bit <= ce;
    wr_clamp_source_select <= cs;
    wr_double_sample_enable <= ds;
    wr_output_disable_bit <= od;
    wr_mode <= vfe_mode_e'(m[1:0]);
    wr_mono_sel <= vfe_chan_e'(s[1:0]);
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr_cfg
  task automatic wr_og(input logic sr, input int ch, input logic [8:0] g);
    @(posedge clk_sys);
    wr_soft_reset <= sr;
    wr_ofs_gain <= !sr;
    wr_chan <= ch[1:0];
    wr_offset <= g[7:0];
    wr_gain <= g;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    wr_soft_reset <= 1'b0;
    wr_ofs_gain <= 1'b0;
  endtask : wr_og
  // one pixel through the partner, words noted before the pulse starts
  task automatic pix(input int m, s, input logic ds);
    cv = 0;
    cr = 0;
    cp = 0;
    for (int c = 0; c < 3; c++)
      if (m == 0 || (m == 1 && c < 2) || (m == 2 && c == s))
        exp_q.push_back({c[1:0], word});
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    cyc(50);
    check("left", exp_q.size(), 0);
    check("vcap", cv, 1);
    check("rcap", cr, ds);
    check("pcap", cp, !ds);
  endtask : pix
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // watchdog well above the expected run of a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    conclude();
  end
  // main sequence
  initial begin
    dummy = $urandom(32'hB3FF);
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wr_cfg(1'b0, 1'b1, 1'b0, 1'b1, 1, 1);
    cyc(2);
    check("por", clamp_enable_bit, 1);
    check("poroe", pixel_output_oe, 0);
    @(posedge clk_sys);
    power_on_reset_n <= 1'b1;
    cyc(4);
    wr_og(1'b1, 0, 9'h000);
    cyc(1);
    check("cen", clamp_enable_bit, 1);
    check("dse", double_sample_enable, 1);
    check("def", {mode, output_disable_bit, chan_power_up}, 6'h07);
    check("gain0", gain_bus, 0);
    for (int c = 0; c < 3; c++) begin
      gn_x[c*9 +: 9] = 9'($urandom);
      ofs_x[c*8 +: 8] = gn_x[c*9 +: 8];
      wr_og(1'b0, c, gn_x[c*9 +: 9]);
    end
    cyc(1);
    check("ofs", offset_bus, ofs_x);
    check("gain", gain_bus, gn_x);
    word = 10'($urandom);
    // clamp truth table; video level outer so it falls only once
    for (int k = 0; k < 16; k++) begin
      wr_cfg(k[2], k[1], !k[1], 1'b0, 0, 0);
      @(posedge clk_sys);
      rs_lvl <= k[0];
      vs_lvl <= k[3];
      cyc(5);
      check("clamp", shared_clamp_control,
        k[2] & (k[1] ? k[0] & k[3] : k[0]));
    end
    for (int c = 0; c < 3; c++)
      exp_q.push_back({c[1:0], word});
    @(posedge clk_sys);
    rs_lvl <= 1'b0;
    vs_lvl <= 1'b0;
    cyc(40);
    check("left", exp_q.size(), 0);
    // output enable from pin and bit, ending with both released
    for (int k = 3; k >= 0; k--) begin
      wr_cfg(1'b1, 1'b0, 1'b1, k[1], 0, 0);
      @(posedge clk_sys);
      output_disable_pin <= k[0];
      cyc(4);
      check("oe", pixel_output_oe, !k[0] && !k[1]);
    end
    // every mode and every single-channel choice, sampling alternating
    for (int i = 0; i < 5; i++) begin
      m = (i < 2) ? i : 2;
      s = (i < 2) ? 0 : i - 2;
      word = 10'($urandom);
      wr_cfg(1'b1, 1'b0, i[0], 1'b0, m, s);
      cyc(1);
      check("mode", {mode, mono_sel}, {m[1:0], s[1:0]});
      check("pwr", chan_power_up,
        (m == 0) ? 7 : (m == 1) ? 3 : 1 << s);
      pix(m, s, i[0]);
    end
    wr_og(1'b1, 0, 9'h000);
    cyc(1);
    check("ofsd", offset_bus, {3{8'h80}});
    conclude();
  end
endmodule : vfe_ctrl_bench

// ---- verification/vfe_scan_timing.sv ----
// scanner timing controller model driving sample pulses and converter words
`timescale 1ns/100ps
`include "vfe_map.svh"
module vfe_scan_timing (
  // clock
  input wire logic clk_sys,
  // requests from the bench
  input wire logic go,
  input wire logic [`VFE_DATA_W-1:0] word,
  input wire logic rs_lvl,
  input wire logic vs_lvl,
  // pins towards the block
  output logic reset_sample_pulse,
  output logic video_sample_pulse,
  output logic [`VFE_DATA_W-1:0] adc_word,
  output logic busy
);
  logic [3:0] step = 4'h0;
  // one pixel takes fifteen cycles (steps 1 to 15); the step wraps back to idle
  always @(posedge clk_sys) begin
    if (go && step == 4'h0)
      step <= 4'h1;
    else if (step != 4'h0)
      step <= step + 4'h1;
  end
  // idle levels come from the bench so clamp cases can be held steady
  assign video_sample_pulse = busy ? (step <= 4'h3) : vs_lvl;
  // reset pulse waits two cycles after the video fall, past the slow edge
  assign reset_sample_pulse = busy ? (step >= 4'h6 && step <= 4'h8)
    : rs_lvl;
  assign adc_word = word;
  assign busy = step != 4'h0;
endmodule : vfe_scan_timing

// ---- verilog/vfe_ctrl.sv ----
// sample, clamp, channel mode and output control of a video front end
// What this block does
// - hold reset and drop writes during power-on reset
// - defaults after reset release, writes accepted
// - output bus tristated by pin or bit
// - each sample is one ten bit word
// - three channel: sample together, convert in turn
// - two channel: red and green, blue off
// - one channel: chosen input, others powered down
// - clamp enable resets to one, gates clamp
// - clamp open when clamp enable zero
// - source zero: clamp follows reset pulse
// - source one: clamp needs both pulses
// - one clamp signal drives all channels
// - double sample enable resets to one
// - video captured on video pulse fall
// - reset level captured on reset pulse fall
// - single sampling: reference pin sampled with video
// - per channel eight bit offset, nine bit gain
// - data nine conversion periods after video fall is seen
`timescale 1ns/100ps
`include "vfe_map.svh"
module vfe_ctrl #(
  parameter int LATENCY = `VFE_LATENCY,
  parameter int CONV_DIV = `VFE_CONV_DIV
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic power_on_reset_n,
  // control write port
  input wire logic wr_en,
  input wire logic wr_soft_reset,
  input wire logic wr_clamp_enable_bit,
  input wire logic wr_clamp_source_select,
  input wire logic wr_double_sample_enable,
  input wire logic wr_output_disable_bit,
  input wire vfe_pkg::vfe_mode_e wr_mode,
  input wire vfe_pkg::vfe_chan_e wr_mono_sel,
  input wire logic [1:0] wr_chan,
  input wire logic wr_ofs_gain,
  input wire logic [`VFE_OFS_W-1:0] wr_offset,
  input wire logic [`VFE_GAIN_W-1:0] wr_gain,
  // sensor timing pins
  input wire logic reset_sample_pulse,
  input wire logic video_sample_pulse,
  input wire logic output_disable_pin,
  // converter result
  input wire logic [`VFE_DATA_W-1:0] adc_word,
  // analogue control
  output logic shared_clamp_control,
  output logic video_capture,
  output logic reset_capture,
  output logic ref_pin_capture,
  output logic [2:0] chan_power_up,
  output logic [1:0] mux_sel,
  output logic [`VFE_OFS_W*3-1:0] offset_bus,
  output logic [`VFE_GAIN_W*3-1:0] gain_bus,
  // status
  output logic clamp_enable_bit,
  output logic double_sample_enable,
  output logic output_disable_bit,
  output logic [1:0] mode,
  output logic [1:0] mono_sel,
  // pixel output
  output logic [`VFE_DATA_W-1:0] pixel_output_bus,
  output logic pixel_output_oe,
  output logic pixel_valid,
  output logic [1:0] pixel_chan
);
  import vfe_pkg::*;

  localparam int CW = $clog2(CONV_DIV + 1);
  localparam int LW = $clog2(LATENCY + 4);

  typedef struct packed {
    logic clamp_en;
    logic clamp_src;
    logic ds_en;
    logic out_dis;
    logic [1:0] mode;
    logic [1:0] mono;
    logic [`VFE_OFS_W*3-1:0] ofs;
    logic [`VFE_GAIN_W*3-1:0] gain;
    logic [CW-1:0] div;
    logic conv_tick;
    logic vs_d;
    logic rs_d;
    logic vs_fell;
    logic [LW-1:0] lat;
    logic lat_run;
    logic [1:0] seq;
    logic seq_run;
    logic clamp;
    logic vcap;
    logic rcap;
    logic pcap;
    logic [2:0] pwr;
    logic [1:0] msel;
    logic [`VFE_DATA_W-1:0] dout;
    logic oe;
    logic valid;
    logic [1:0] chan;
  } vfe_ctrl_s;

  vfe_ctrl_s st;
  vfe_ctrl_s next_st;

  logic [3:0] pin_sync;
  logic rsp;
  logic vsp;
  logic odp;
  logic por_n;

  // number of channels converted per pixel in a mode
  function automatic logic [1:0] chans_of(input logic [1:0] m);
    case (m)
      VFE_THREE: chans_of = 2'h3;
      VFE_TWO: chans_of = 2'h2;
      default: chans_of = 2'h1;
    endcase
  endfunction : chans_of

  // pins and the supply monitor come from outside the clock domain
  vfe_sync #(.W(4)) vfe_sync_i (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d({power_on_reset_n, output_disable_pin,
        video_sample_pulse, reset_sample_pulse}),
    .q(pin_sync)
  );
  assign rsp = pin_sync[0];
  assign vsp = pin_sync[1];
  assign odp = pin_sync[2];
  assign por_n = pin_sync[3];

  // next state of the whole block
  always_comb begin
    next_st = st;
    // conversion clock enable from a divider
    next_st.conv_tick = 1'b0;
    if (st.div == CW'(CONV_DIV - 1)) begin
      next_st.div = '0;
      next_st.conv_tick = 1'b1;
    end else begin
      next_st.div = st.div + CW'(1);
    end
    // control writes; software reset restores defaults
    if (wr_en && wr_soft_reset) begin
      next_st.clamp_en = `VFE_CLAMP_EN_RST;
      next_st.ds_en = `VFE_DS_EN_RST;
      next_st.clamp_src = 1'b0;
      next_st.out_dis = `VFE_OUT_DIS_RST;
      next_st.mode = `VFE_MODE_RST;
      next_st.mono = `VFE_MONO_SEL_RST;
      next_st.ofs = {3{`VFE_OFS_RST}};
      next_st.gain = {3{`VFE_GAIN_RST}};
    end else if (wr_en && wr_ofs_gain) begin
      // per channel offset and gain settings
      next_st.ofs[wr_chan*`VFE_OFS_W +: `VFE_OFS_W] = wr_offset;
      next_st.gain[wr_chan*`VFE_GAIN_W +: `VFE_GAIN_W] = wr_gain;
    end else if (wr_en) begin
      next_st.clamp_en = wr_clamp_enable_bit;
      next_st.clamp_src = wr_clamp_source_select;
      next_st.ds_en = wr_double_sample_enable;
      next_st.out_dis = wr_output_disable_bit;
      next_st.mode = wr_mode;
      next_st.mono = wr_mono_sel;
    end
    // edge detect on synchronised pulses
    next_st.vs_d = vsp;
    next_st.rs_d = rsp;
    next_st.vs_fell = st.vs_d & ~vsp;
    // shared clamp drive for all three channels
    if (!st.clamp_en) begin
      next_st.clamp = 1'b0;
    end else if (st.clamp_src) begin
      next_st.clamp = rsp & vsp;
    end else begin
      next_st.clamp = rsp;
    end
    // sampling strobes
    next_st.vcap = st.vs_d & ~vsp;
    next_st.rcap = st.ds_en & st.rs_d & ~rsp;
    next_st.pcap = ~st.ds_en & st.vs_d & ~vsp;
    // channel power by mode
    case (st.mode)
      VFE_THREE: next_st.pwr = 3'h7;
      VFE_TWO: next_st.pwr = 3'h3;
      default: next_st.pwr = 3'h1 << st.mono;
    endcase
    // latency count from the first conversion edge after video fall
    if (st.vs_fell && !st.lat_run) begin
      next_st.lat_run = 1'b1;
      next_st.lat = '0;
    end else if (st.lat_run && st.conv_tick) begin
      if (st.lat == LW'(LATENCY)) begin
        next_st.lat_run = 1'b0;
        next_st.seq_run = 1'b1;
        next_st.seq = 2'h0;
      end else begin
        next_st.lat = st.lat + LW'(1);
      end
    end
    // present words one per conversion period, red first unless one channel
    next_st.valid = 1'b0;
    if (st.seq_run && st.conv_tick) begin
      next_st.valid = 1'b1;
      next_st.dout = adc_word;
      next_st.chan = (st.mode == VFE_ONE) ? st.mono : st.seq;
      next_st.msel = next_st.chan;
      if (st.seq == chans_of(st.mode) - 2'h1) begin
        next_st.seq_run = 1'b0;
      end else begin
        next_st.seq = st.seq + 2'h1;
      end
    end
    // bus released by pin or bit
    next_st.oe = ~(odp | st.out_dis);
  end

  // held in reset while the supply monitor is low; writes dropped
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !por_n) begin
      st <= '0;
      st.clamp_en <= `VFE_CLAMP_EN_RST;
      st.ds_en <= `VFE_DS_EN_RST;
      st.mode <= `VFE_MODE_RST;
      st.ofs <= {3{`VFE_OFS_RST}};
      st.pwr <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  // one clamp line reaches every channel switch
  assign shared_clamp_control = st.clamp;
  assign video_capture = st.vcap;
  assign reset_capture = st.rcap;
  assign ref_pin_capture = st.pcap;
  assign chan_power_up = st.pwr;
  assign mux_sel = st.msel;
  assign offset_bus = st.ofs;
  assign gain_bus = st.gain;
  assign clamp_enable_bit = st.clamp_en;
  assign double_sample_enable = st.ds_en;
  assign output_disable_bit = st.out_dis;
  assign mode = st.mode;
  assign mono_sel = st.mono;
  assign pixel_output_bus = st.dout;
  assign pixel_output_oe = st.oe;
  assign pixel_valid = st.valid;
  assign pixel_chan = st.chan;

  // clamp never closes while disabled
  property p_clamp_off;
    @(posedge clk_sys) disable iff (sys_rst)
      !st.clamp_en |=> !shared_clamp_control;
  endproperty
  a_clamp_off: assert property (p_clamp_off)
    else $error("clamp closed while disabled");

  // direct source follows the reset pulse
  property p_clamp_direct;
    @(posedge clk_sys) disable iff (sys_rst || !por_n)
      st.clamp_en && !st.clamp_src && rsp |=> shared_clamp_control;
  endproperty
  a_clamp_direct: assert property (p_clamp_direct)
    else $error("clamp did not follow reset pulse");

  // combined source needs the video pulse too
  property p_clamp_and;
    @(posedge clk_sys) disable iff (sys_rst || !por_n)
      st.clamp_en && st.clamp_src && !vsp |=> !shared_clamp_control;
  endproperty
  a_clamp_and: assert property (p_clamp_and)
    else $error("clamp closed without video pulse");

  // disabled output whenever the bit is set
  property p_out_dis;
    @(posedge clk_sys) disable iff (sys_rst || !por_n)
      st.out_dis |=> !pixel_output_oe;
  endproperty
  a_out_dis: assert property (p_out_dis)
    else $error("bus driven while disabled");

  // video capture strobe tied to the pulse fall
  property p_vcap;
    @(posedge clk_sys) disable iff (sys_rst || !por_n)
      video_capture |-> $past(st.vs_d) && !$past(vsp);
  endproperty
  a_vcap: assert property (p_vcap)
    else $error("video capture without pulse fall");

  // reset capture only while double sampling
  property p_rcap;
    @(posedge clk_sys) disable iff (sys_rst || !por_n)
      reset_capture |-> $past(st.ds_en);
  endproperty
  a_rcap: assert property (p_rcap)
    else $error("reset capture in single sampling");

  // reference pin sampled together with video
  property p_pcap;
    @(posedge clk_sys) disable iff (sys_rst || !por_n)
      ref_pin_capture |-> video_capture && !$past(st.ds_en);
  endproperty
  a_pcap: assert property (p_pcap)
    else $error("reference capture misplaced");

  // power pattern matches two channel mode
  property p_two_pwr;
    @(posedge clk_sys) disable iff (sys_rst || !por_n)
      st.mode == VFE_TWO ##1 st.mode == VFE_TWO |-> chan_power_up == 3'h3;
  endproperty
  a_two_pwr: assert property (p_two_pwr)
    else $error("blue powered in two channel mode");

  // writes are lost while the supply monitor holds reset
  property p_por;
    @(posedge clk_sys) disable iff (sys_rst)
      !por_n |=> clamp_enable_bit && double_sample_enable;
  endproperty
  a_por: assert property (p_por)
    else $error("state changed under power-on reset");
endmodule : vfe_ctrl

// ---- verilog/vfe_map.svh ----
// constants for the video front end sample and clamp control
`ifndef VFE_MAP_SVH
`define VFE_MAP_SVH
`define VFE_DATA_W 10
`define VFE_OFS_W 8
`define VFE_GAIN_W 9
`define VFE_LATENCY 7
`define VFE_CONV_DIV 2
`define VFE_CLAMP_EN_RST 1'b1
`define VFE_DS_EN_RST 1'b1
`define VFE_OUT_DIS_RST 1'b0
`define VFE_MODE_RST 2'h0
`define VFE_MONO_SEL_RST 2'h0
`define VFE_OFS_RST 8'h80
`define VFE_GAIN_RST 9'h000
`endif

// ---- verilog/vfe_pkg.sv ----
// types for the video front end sample and clamp control
package vfe_pkg;
  typedef enum logic [1:0] {VFE_THREE, VFE_TWO, VFE_ONE} vfe_mode_e;
  typedef enum logic [1:0] {VFE_RED, VFE_GREEN, VFE_BLUE} vfe_chan_e;
endpackage : vfe_pkg

// ---- verilog/vfe_sync.sv ----
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/100ps
module vfe_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } vfe_sync_s;
  vfe_sync_s st;
  vfe_sync_s next_st;

  // first stage feeds only the second stage
  always_comb begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule : vfe_sync
